// ---- uif_irq_format.sv ----
// Interrupt identification with read-to-clear, line format and FIFO setup
// registers behind an AXI4-Lite slave. Assumes synchronous inputs on CORE_CLK
// and event inputs as one-cycle pulses from the receiver and transmitter.
`timescale 1ns/10ps
module uif_irq_format
   import uif_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // AXI4-Lite write address
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   // AXI4-Lite write data
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read address
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   // AXI4-Lite read data
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Interrupt source events
   input wire logic LINE_CONDITION_EVT,
   input wire logic RX_TIMEOUT_EVT,
   input wire logic TX_HOLDING_EMPTY_EVT,
   input wire logic MODEM_CHANGE_EVT,
   input wire logic [6:0] RX_FIFO_COUNT,
   // Serial data path
   input wire logic TX_SERIAL_IN,
   output logic TX_SERIAL_OUT,
   input wire logic [7:0] TX_DATA,
   output logic TX_PARITY_BIT,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_PARITY_IN,
   output logic RX_PARITY_ERR,
   // Decoded configuration
   output logic [3:0] WORD_BITS,
   output logic [2:0] STOP_HALF_BITS,
   output logic PARITY_ENABLE,
   output logic DIVISOR_ACCESS,
   output logic [15:0] DIVISOR,
   output logic FIFO_ENABLE,
   output logic FIFO_DEEP,
   output logic INT_PENDING
);

   // ****
   // State
   // ****
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] line_fmt;
      logic [7:0] fifo_setup;
      logic [15:0] divisor;
      logic [UIF_NUM_SRC-1:0] pending;
      logic cur_active;
      uif_src_t cur_src;
      logic tx_out;
      logic tx_par;
      logic rx_err;
      logic [3:0] word_bits;
      logic [2:0] stop_half;
   } uif_state_t;

   uif_state_t s;
   uif_state_t next_s;

   uif_fmt_if fmt_bus ();

   logic [UIF_NUM_SRC-1:0] evt;
   logic [6:0] trig_level;
   logic [7:0] source_id;
   logic fifo_en;
   logic fifo_deep;
   logic div_access;

   // ****
   // Frame format calculator
   // ****
   uif_frame_calc u_calc (
      .f (fmt_bus.calc)
   );

   // Feed format and data to the calculator
   assign fmt_bus.fmt = s.line_fmt;
   assign fmt_bus.tx_data = TX_DATA;
   assign fmt_bus.rx_data = RX_DATA;
   assign fmt_bus.rx_par = RX_PARITY_IN;

   // Decoded configuration
   assign fifo_en = s.fifo_setup[UIF_FS_ENABLE];
   assign fifo_deep = s.fifo_setup[UIF_FS_DEEP];
   assign div_access = s.line_fmt[UIF_LF_DIV_ACCESS];

   // ****
   // Interrupt sources
   // ****

   // Receive trigger level; one entry when FIFOs are off
   always_comb begin
      trig_level = UIF_TRIG16_0;
      if (fifo_en) begin
         case ({fifo_deep, s.fifo_setup[UIF_FS_TRIG_LO+1:UIF_FS_TRIG_LO]})
            3'h0: trig_level = UIF_TRIG16_0;
            3'h1: trig_level = UIF_TRIG16_1;
            3'h2: trig_level = UIF_TRIG16_2;
            3'h3: trig_level = UIF_TRIG16_3;
            3'h4: trig_level = UIF_TRIG64_0;
            3'h5: trig_level = UIF_TRIG64_1;
            3'h6: trig_level = UIF_TRIG64_2;
            default: trig_level = UIF_TRIG64_3;
         endcase
      end
   end

   // Event vector in priority order
   always_comb begin
      evt = '0;
      evt[UIF_SRC_LINE] = LINE_CONDITION_EVT;
      evt[UIF_SRC_RXDATA] = (RX_FIFO_COUNT == trig_level);
      evt[UIF_SRC_TIMEOUT] = RX_TIMEOUT_EVT;
      evt[UIF_SRC_THR] = TX_HOLDING_EMPTY_EVT;
      evt[UIF_SRC_MODEM] = MODEM_CHANGE_EVT;
   end

   // Identification value of the latched source
   always_comb begin
      source_id = 8'h01;
      if (s.cur_active) begin
         case (s.cur_src)
            UIF_SRC_LINE: source_id[3:1] = UIF_ID_LINE;
            UIF_SRC_RXDATA: source_id[3:1] = UIF_ID_RXDATA;
            UIF_SRC_TIMEOUT: source_id[3:1] = UIF_ID_TIMEOUT;
            UIF_SRC_THR: source_id[3:1] = UIF_ID_THR;
            UIF_SRC_MODEM: source_id[3:1] = UIF_ID_MODEM;
            default: source_id[3:1] = UIF_ID_MODEM;
         endcase
         source_id[0] = 1'b0;
      end
      source_id[7] = fifo_en;
      source_id[6] = fifo_en;
      source_id[5] = fifo_en && fifo_deep;
      source_id[4] = 1'b0;
   end

   // Read data for an address; identification and FIFO setup hidden while divisor access is on
   function automatic logic [32:0] read_mux(input uif_state_t st, input logic [7:0] addr,
                                            input logic [7:0] sid);
      logic [32:0] r;
      r = {1'b0, 32'h00000000};
      case (addr)
         UIF_OFS_SOURCE_ID: begin
            if (!st.line_fmt[UIF_LF_DIV_ACCESS]) begin
               r[7:0] = sid;
            end else begin
               r[32] = 1'b1;
            end
         end
         UIF_OFS_LINE_FMT: r[7:0] = st.line_fmt;
         UIF_OFS_FIFO_SETUP: begin
            if (!st.line_fmt[UIF_LF_DIV_ACCESS]) begin
               r[7:0] = st.fifo_setup;
            end else begin
               r[32] = 1'b1;
            end
         end
         UIF_OFS_DIVISOR: begin
            if (st.line_fmt[UIF_LF_DIV_ACCESS]) begin
               r[15:0] = st.divisor;
            end else begin
               r[32] = 1'b1;
            end
         end
         default: r[32] = 1'b1;
      endcase
      return r;
   endfunction : read_mux

   // ****
   // Next state
   // ****
   always_comb begin
      logic [32:0] rd;
      logic isr_read;
      logic wr_err;
      rd = {1'b0, 32'h00000000};
      isr_read = 1'b0;
      wr_err = 1'b0;
      next_s = s;

      // Response handshakes release the channels
      if (s.bvalid && S_AXI_BREADY) begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && S_AXI_RREADY) begin
         next_s.rvalid = 1'b0;
      end

      // Capture write address and data in either order
      if (S_AXI_AWVALID && s.awready) begin
         next_s.aw_full = 1'b1;
         next_s.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && s.wready) begin
         next_s.w_full = 1'b1;
         next_s.w_data = S_AXI_WDATA;
         next_s.w_strb = S_AXI_WSTRB;
      end

      // Perform a write once both halves are held
      if (s.aw_full && s.w_full && !s.bvalid) begin
         case (s.aw_addr)
            UIF_OFS_SOURCE_ID: wr_err = div_access;
            UIF_OFS_LINE_FMT: begin
               if (s.w_strb[0]) begin
                  next_s.line_fmt = s.w_data[7:0];
               end
            end
            UIF_OFS_FIFO_SETUP: begin
               if (div_access) begin
                  wr_err = 1'b1;
               end else if (s.w_strb[0]) begin
                  // Other bits program only with the enable bit set
                  if (s.w_data[UIF_FS_ENABLE]) begin
                     next_s.fifo_setup = s.w_data[7:0] & UIF_FS_STORE_MASK;
                  end else begin
                     next_s.fifo_setup[UIF_FS_ENABLE] = 1'b0;
                  end
               end
            end
            UIF_OFS_DIVISOR: begin
               if (!div_access) begin
                  wr_err = 1'b1;
               end else begin
                  if (s.w_strb[0]) begin
                     next_s.divisor[7:0] = s.w_data[7:0];
                  end
                  if (s.w_strb[1]) begin
                     next_s.divisor[15:8] = s.w_data[15:8];
                  end
               end
            end
            default: wr_err = 1'b1;
         endcase
         next_s.aw_full = 1'b0;
         next_s.w_full = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = wr_err ? UIF_RESP_SLVERR : UIF_RESP_OKAY;
      end

      // Read access and its side effect
      if (S_AXI_ARVALID && s.arready) begin
         rd = read_mux(s, S_AXI_ARADDR, source_id);
         next_s.rvalid = 1'b1;
         next_s.rdata = rd[31:0];
         next_s.rresp = rd[32] ? UIF_RESP_SLVERR : UIF_RESP_OKAY;
         isr_read = (S_AXI_ARADDR == UIF_OFS_SOURCE_ID) && !div_access;
      end

      // Reading clears only the reported source
      if (isr_read && s.cur_active) begin
         next_s.pending[s.cur_src] = 1'b0;
         next_s.cur_active = 1'b0;
      end

      // New events set pending; a set beats a same-cycle clear
      for (int i = 0; i < UIF_NUM_SRC; i++) begin
         if (evt[i]) begin
            next_s.pending[i] = 1'b1;
         end
      end

      // Latch the top pending source only while none is held
      if (!s.cur_active && (s.pending != '0)) begin
         next_s.cur_active = 1'b1;
         next_s.cur_src = UIF_SRC_MODEM;
         for (int i = UIF_NUM_SRC - 1; i >= 0; i--) begin
            if (s.pending[i]) begin
               next_s.cur_src = uif_src_t'(i[2:0]);
            end
         end
      end

      // Ready flags follow channel occupancy
      next_s.awready = !next_s.aw_full;
      next_s.wready = !next_s.w_full;
      next_s.arready = !next_s.rvalid;

      // Serial output and frame outputs
      next_s.tx_out = s.line_fmt[UIF_LF_BREAK] ? 1'b0 : TX_SERIAL_IN;
      next_s.tx_par = fmt_bus.tx_par;
      next_s.rx_err = fmt_bus.rx_err;
      next_s.word_bits = fmt_bus.word_bits;
      next_s.stop_half = fmt_bus.stop_half;
   end

   // ****
   // State register
   // ****
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         s <= '0;
         s.cur_src <= UIF_SRC_LINE;
         s.line_fmt <= UIF_RST_LINE_FMT;
         s.fifo_setup <= UIF_RST_FIFO_SETUP;
         s.divisor <= UIF_RST_DIVISOR;
         s.tx_out <= 1'b1; // Idle line is high
         s.word_bits <= UIF_MIN_WORD_BITS;
         s.stop_half <= UIF_STOP_HALF_ONE;
      end else begin
         s <= next_s;
      end
   end

   // ****
   // Outputs
   // ****
   assign S_AXI_AWREADY = s.awready;
   assign S_AXI_WREADY = s.wready;
   assign S_AXI_BVALID = s.bvalid;
   assign S_AXI_BRESP = s.bresp;
   assign S_AXI_ARREADY = s.arready;
   assign S_AXI_RVALID = s.rvalid;
   assign S_AXI_RDATA = s.rdata;
   assign S_AXI_RRESP = s.rresp;
   assign TX_SERIAL_OUT = s.tx_out;
   assign TX_PARITY_BIT = s.tx_par;
   assign RX_PARITY_ERR = s.rx_err;
   assign WORD_BITS = s.word_bits;
   assign STOP_HALF_BITS = s.stop_half;
   assign PARITY_ENABLE = s.line_fmt[UIF_LF_PAR_EN];
   assign DIVISOR_ACCESS = s.line_fmt[UIF_LF_DIV_ACCESS];
   assign DIVISOR = s.divisor;
   assign FIFO_ENABLE = s.fifo_setup[UIF_FS_ENABLE];
   assign FIFO_DEEP = s.fifo_setup[UIF_FS_DEEP];
   assign INT_PENDING = s.cur_active;

endmodule : uif_irq_format

// ---- uif_pkg.sv ----
// Constants, field positions and source codes for the interrupt identification
// and line format block. Assumes a 32-bit AXI4-Lite master; registers are 8-bit except the 16-bit divisor.
//
// How it works
// - Identification read returns the code of the latched source, the top pending one at latch time.
// - A latched source is held until read; no other source is taken meanwhile.
// - Reading identification clears only the reported source; others stay pending.
// - Line condition is top priority, bits 3..0 read 0110.
// - Received data available is second priority, bits 3..0 read 0100.
// - Receive timeout is third priority, bits 3..0 read 1100.
// - Transmit holding empty is fourth priority, bits 3..0 read 0010.
// - Modem change is lowest priority, bits 3..0 read 0000 with pending.
// - Bits 7 and 6 read one with FIFOs enabled, zero otherwise.
// - Bit 5 reads one in 64-entry mode, zero in 16-entry mode.
// - Bit 0 is zero while a source is latched, one when none is latched.
// - Format bit 7 exposes divisor latch and hides identification and FIFO setup.
// - Format bit 6 holds the serial output low until cleared.
// - Format bit 3 enables parity generate and check; zero means none.
// - Parity on, bits 5..4 = 00: odd parity.
// - Parity on, bits 5..4 = 01: even parity.
// - Parity on, bits 5..4 = 10: parity bit forced one.
// - Parity on, bits 5..4 = 11: parity bit forced zero.
// - Bit 2 zero gives one stop; one gives 1.5 (5-bit) or 2 stops.
// - Bits 1..0 select 5, 6, 7 or 8 data bits.
// - Data available sets when receive count equals the trigger level.
package uif_pkg;

   // ****
   // Register byte offsets
   // ****
   localparam logic [7:0] UIF_OFS_SOURCE_ID = 8'h00;
   localparam logic [7:0] UIF_OFS_LINE_FMT = 8'h04;
   localparam logic [7:0] UIF_OFS_FIFO_SETUP = 8'h08;
   localparam logic [7:0] UIF_OFS_DIVISOR = 8'h0C;

   // ****
   // Reset values
   // ****
   localparam logic [7:0] UIF_RST_LINE_FMT = 8'h00;
   localparam logic [7:0] UIF_RST_FIFO_SETUP = 8'h00;
   localparam logic [15:0] UIF_RST_DIVISOR = 16'h0000;

   // ****
   // Field positions
   // ****
   localparam int UIF_LF_DIV_ACCESS = 7;
   localparam int UIF_LF_BREAK = 6;
   localparam int UIF_LF_FORCE = 5;
   localparam int UIF_LF_EVEN = 4;
   localparam int UIF_LF_PAR_EN = 3;
   localparam int UIF_LF_STOP = 2;
   localparam int UIF_FS_ENABLE = 0;
   localparam int UIF_FS_DEEP = 5;
   localparam int UIF_FS_TRIG_LO = 6;
   localparam logic [7:0] UIF_FS_STORE_MASK = 8'hE9;

   // ****
   // AXI responses and frame figures
   // ****
   localparam logic [1:0] UIF_RESP_OKAY = 2'h0;
   localparam logic [1:0] UIF_RESP_SLVERR = 2'h2;
   localparam logic [3:0] UIF_MIN_WORD_BITS = 4'h5;
   localparam logic [2:0] UIF_STOP_HALF_ONE = 3'h2;
   localparam logic [2:0] UIF_STOP_HALF_ONE_HALF = 3'h3;
   localparam logic [2:0] UIF_STOP_HALF_TWO = 3'h4;

   // ****
   // Interrupt sources, index is priority order
   // ****
   typedef enum logic [2:0] {
      UIF_SRC_LINE = 3'b000,
      UIF_SRC_RXDATA = 3'b001,
      UIF_SRC_TIMEOUT = 3'b010,
      UIF_SRC_THR = 3'b011,
      UIF_SRC_MODEM = 3'b100
   } uif_src_t;
   localparam int UIF_NUM_SRC = 5;

   // Bits 3..1 of the identification value per source
   localparam logic [2:0] UIF_ID_LINE = 3'h3;
   localparam logic [2:0] UIF_ID_RXDATA = 3'h2;
   localparam logic [2:0] UIF_ID_TIMEOUT = 3'h6;
   localparam logic [2:0] UIF_ID_THR = 3'h1;
   localparam logic [2:0] UIF_ID_MODEM = 3'h0;

   // Receive trigger levels, 16- and 64-entry modes
   localparam logic [6:0] UIF_TRIG16_0 = 7'h01;
   localparam logic [6:0] UIF_TRIG16_1 = 7'h04;
   localparam logic [6:0] UIF_TRIG16_2 = 7'h08;
   localparam logic [6:0] UIF_TRIG16_3 = 7'h0E;
   localparam logic [6:0] UIF_TRIG64_0 = 7'h01;
   localparam logic [6:0] UIF_TRIG64_1 = 7'h10;
   localparam logic [6:0] UIF_TRIG64_2 = 7'h20;
   localparam logic [6:0] UIF_TRIG64_3 = 7'h38;

endpackage : uif_pkg

// ---- uif_fmt_if.sv ----
// Interface between the register block and the frame format calculator.
// Assumes both ends sit on the same clock; the calculator is combinational.
`timescale 1ns/10ps
interface uif_fmt_if;
   logic [7:0] fmt;
   logic [7:0] tx_data;
   logic [7:0] rx_data;
   logic rx_par;
   logic tx_par;
   logic rx_err;
   logic [3:0] word_bits;
   logic [2:0] stop_half;

   // Register side drives format and data
   modport ctl (output fmt, tx_data, rx_data, rx_par, input tx_par, rx_err, word_bits, stop_half);
   // Calculator side returns parity and framing
   modport calc (input fmt, tx_data, rx_data, rx_par, output tx_par, rx_err, word_bits, stop_half);
endinterface : uif_fmt_if

// ---- uif_frame_calc.sv ----
// Frame format calculator: parity bit, parity check, word and stop length.
// Data bits above the word length are masked off here; the caller passes them unmasked.
`timescale 1ns/10ps
module uif_frame_calc
   import uif_pkg::*;
(
   // Format and data
   uif_fmt_if.calc f
);

   logic [7:0] len_mask;
   logic [7:0] tx_masked;
   logic [7:0] rx_masked;
   logic tx_calc;
   logic rx_calc;

   // Mask data to the selected word length
   always_comb begin
      case (f.fmt[1:0])
         2'h0: len_mask = 8'h1F;
         2'h1: len_mask = 8'h3F;
         2'h2: len_mask = 8'h7F;
         default: len_mask = 8'hFF;
      endcase
      tx_masked = f.tx_data & len_mask;
      rx_masked = f.rx_data & len_mask;
   end

   // Parity bit per format for a given data word
   function automatic logic par_of(input logic [7:0] fmt, input logic [7:0] d);
      logic r;
      r = 1'b0;
      if (!fmt[UIF_LF_PAR_EN]) begin
         r = 1'b0;
      end else if (!fmt[UIF_LF_FORCE] && !fmt[UIF_LF_EVEN]) begin
         r = ~(^d);
      end else if (!fmt[UIF_LF_FORCE] && fmt[UIF_LF_EVEN]) begin
         r = ^d;
      end else if (!fmt[UIF_LF_EVEN]) begin
         r = 1'b1;
      end else begin
         r = 1'b0;
      end
      return r;
   endfunction : par_of

   // Generate and check parity
   always_comb begin
      tx_calc = par_of(f.fmt, tx_masked);
      rx_calc = par_of(f.fmt, rx_masked);
      f.tx_par = tx_calc;
      f.rx_err = f.fmt[UIF_LF_PAR_EN] && (f.rx_par != rx_calc);
   end

   // Word length and stop length in half bit times
   always_comb begin
      f.word_bits = UIF_MIN_WORD_BITS + {2'h0, f.fmt[1:0]};
      if (!f.fmt[UIF_LF_STOP]) begin
         f.stop_half = UIF_STOP_HALF_ONE;
      end else if (f.fmt[1:0] == 2'h0) begin
         f.stop_half = UIF_STOP_HALF_ONE_HALF;
      end else begin
         f.stop_half = UIF_STOP_HALF_TWO;
      end
   end

endmodule : uif_frame_calc

// ---- uif_remote_peer.sv ----
// Far-side serial partner: checks and answers with the programmed parity.
// Assumes the bench mirrors the line format written to the block.
`timescale 1ns/10ps
module uif_remote_peer
   import uif_pkg::*;
(
   // Format and character
   input wire logic [7:0] fmt,
   input wire logic [7:0] char_in,
   input wire logic corrupt,
   // Line side
   output logic [7:0] rx_char,
   output logic rx_par,
   output logic exp_par
);
   logic [7:0] m;
   // Parity of the masked word per mode, same format both ways
   always_comb begin
      m = char_in & (8'hFF >> (2'h3 - fmt[1:0]));
      case (fmt[5:4])
         2'h0: exp_par = ~^m;
         2'h1: exp_par = ^m;
         2'h2: exp_par = 1'b1;
         default: exp_par = 1'b0;
      endcase
      rx_char = char_in;
      rx_par = exp_par ^ corrupt;
   end
endmodule : uif_remote_peer

// ---- uif_irq_format_monitor.sv ----
// Checker for the identification and line format block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module uif_irq_format_monitor
   import uif_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // Bus handshakes
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_BVALID,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   // Events and serial path
   input wire logic LINE_CONDITION_EVT,
   input wire logic TX_SERIAL_IN,
   input wire logic TX_SERIAL_OUT,
   input wire logic RX_PARITY_ERR,
   // Configuration and status
   input wire logic [3:0] WORD_BITS,
   input wire logic [2:0] STOP_HALF_BITS,
   input wire logic PARITY_ENABLE,
   input wire logic DIVISOR_ACCESS,
   input wire logic FIFO_ENABLE,
   input wire logic FIFO_DEEP,
   input wire logic INT_PENDING
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   logic rd_id;
   // Identification read taken
   assign rd_id = S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == UIF_OFS_SOURCE_ID && !DIVISOR_ACCESS;
   // ****
   // Properties
   // ****
   AST_LATCH: assert property (LINE_CONDITION_EVT && !INT_PENDING |-> ##[1:2] INT_PENDING)
      else $error("event not latched");
   AST_HOLD: assert property (INT_PENDING && !rd_id |=> INT_PENDING)
      else $error("latched source lost");
   AST_CLEAR: assert property (rd_id && INT_PENDING |=> !INT_PENDING)
      else $error("read did not clear");
   AST_IDLE: assert property (rd_id && !INT_PENDING |=> S_AXI_RVALID && S_AXI_RDATA[0])
      else $error("idle bit wrong");
   AST_BUSY: assert property (rd_id && INT_PENDING |=> !S_AXI_RDATA[0] && !S_AXI_RDATA[4])
      else $error("pending bits wrong");
   AST_FIFO_BITS: assert property (rd_id |=> S_AXI_RDATA[7:5] == {$past(FIFO_ENABLE), $past(FIFO_ENABLE),
      $past(FIFO_ENABLE) && $past(FIFO_DEEP)})
      else $error("fifo bits wrong");
   AST_BREAK: assert property (!$past(RESET) && TX_SERIAL_OUT != $past(TX_SERIAL_IN) |-> !TX_SERIAL_OUT)
      else $error("serial out not passed or low");
   AST_STOP: assert property (STOP_HALF_BITS != UIF_STOP_HALF_ONE |->
      STOP_HALF_BITS == ((WORD_BITS == 4'h5) ? UIF_STOP_HALF_ONE_HALF : UIF_STOP_HALF_TWO))
      else $error("stop length wrong");
   AST_WORD: assert property (WORD_BITS >= 4'h5 && WORD_BITS <= 4'h8)
      else $error("word length out of range");
   AST_PAR_OFF: assert property (!PARITY_ENABLE && !$past(PARITY_ENABLE) |-> !RX_PARITY_ERR)
      else $error("parity error while off");
   AST_WRESP: assert property (S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:3] S_AXI_BVALID)
      else $error("no write response");
endmodule : uif_irq_format_monitor

bind uif_irq_format uif_irq_format_monitor i_mon (.*);

// ---- test_uif_irq_format.sv ----
// Bench for the identification and line format block over AXI4-Lite.
// Assumes package, design, checker and line partner compiled before it.
`timescale 1ns/10ps
module test_uif_irq_format
   import uif_pkg::*;
;
   logic CORE_CLK, RESET, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic ev_line, ev_to, ev_thr, ev_mdm, tx_in, tx_out, tx_par, rx_err, div_acc, corrupt, rx_par_in, exp_par;
   logic [7:0] awaddr, araddr, tx_data, fmt_m, rx_char;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [6:0] rx_cnt;
   logic [3:0] word_bits;
   logic [2:0] stop_half;
   logic [15:0] divisor;
   logic [7:0] codes [6] = '{8'h06, 8'h04, 8'h0C, 8'h02, 8'h00, 8'h01};
   logic [7:0] modes [6] = '{8'h03, 8'h0B, 8'h1B, 8'h2B, 8'h3B, 8'h08};
   int fail_count = 0, comparisons = 0, cycles = 0;

   uif_irq_format i_dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .LINE_CONDITION_EVT(ev_line), .RX_TIMEOUT_EVT(ev_to),
      .TX_HOLDING_EMPTY_EVT(ev_thr), .MODEM_CHANGE_EVT(ev_mdm), .RX_FIFO_COUNT(rx_cnt), .TX_SERIAL_IN(tx_in),
      .TX_SERIAL_OUT(tx_out), .TX_DATA(tx_data), .TX_PARITY_BIT(tx_par), .RX_DATA(rx_char),
      .RX_PARITY_IN(rx_par_in), .RX_PARITY_ERR(rx_err), .WORD_BITS(word_bits), .STOP_HALF_BITS(stop_half),
      .PARITY_ENABLE(), .DIVISOR_ACCESS(div_acc), .DIVISOR(divisor), .FIFO_ENABLE(), .FIFO_DEEP(), .INT_PENDING());
   uif_remote_peer i_peer (.fmt(fmt_m), .char_in(tx_data), .corrupt(corrupt), .rx_char(rx_char),
      .rx_par(rx_par_in), .exp_par(exp_par));

   // ****
   // Clock, timeout and tasks
   // ****
   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end
   // Cut a hang short
   always @(posedge CORE_CLK) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         end_sim();
      end
   end
   task end_sim;
      $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Write, holding each channel until taken
   task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge CORE_CLK);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk({32'h0, bresp}, {32'h0, er});
   endtask : wc
   task automatic rc(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
      @(posedge CORE_CLK);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk({rresp, rdata}, {er, ed});
   endtask : rc
   task automatic rid(input logic [31:0] ed);
      rc(UIF_OFS_SOURCE_ID, UIF_RESP_OKAY, ed);
   endtask : rid
   // One-cycle events: line, data, timeout, holding empty, modem
   task automatic pulse(input logic [4:0] m, input logic [6:0] cnt);
      @(posedge CORE_CLK);
      {ev_line, ev_to, ev_thr, ev_mdm} <= {m[4], m[2:0]};
      rx_cnt <= m[3] ? cnt : 7'h00;
      @(posedge CORE_CLK);
      {ev_line, ev_to, ev_thr, ev_mdm} <= 4'h0;
      rx_cnt <= 7'h00;
   endtask : pulse

   // ****
   // Main sequence
   // ****
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, ev_line, ev_to, ev_thr, ev_mdm, corrupt} = 10'h000;
      {awaddr, araddr, tx_data, fmt_m, wdata, rx_cnt} = 71'h0;
      tx_in = 1'b1;
      RESET = 1'b1;
      repeat (6) @(posedge CORE_CLK);
      RESET <= 1'b0;
      rid(32'h1);
      rc(UIF_OFS_LINE_FMT, UIF_RESP_OKAY, 32'h0);
      chk({27'h0, word_bits, stop_half}, {27'h0, 4'h5, 3'h2});
      wc(UIF_OFS_SOURCE_ID, 32'hFF, UIF_RESP_OKAY);
      rid(32'h1);
      wc(8'h10, 32'h0, UIF_RESP_SLVERR);
      rc(8'h10, UIF_RESP_SLVERR, 32'h0);
      // All sources at once, then one by one in priority
      pulse(5'h1F, 7'h01);
      for (int i = 0; i < 6; i++) rid({24'h0, codes[i]});
      // Lower source latched first is held
      pulse(5'h01, 7'h00);
      pulse(5'h10, 7'h00);
      rid(32'h0);
      rid(32'h6);
      // FIFO mode bits and trigger levels in both depths
      wc(UIF_OFS_FIFO_SETUP, 32'h41, UIF_RESP_OKAY);
      rid(32'hC1);
      pulse(5'h08, 7'h04);
      rid(32'hC4);
      wc(UIF_OFS_FIFO_SETUP, 32'hE1, UIF_RESP_OKAY);
      pulse(5'h08, 7'h20);
      rid(32'hE1);
      pulse(5'h08, 7'h38);
      rid(32'hE4);
      wc(UIF_OFS_FIFO_SETUP, 32'h0, UIF_RESP_OKAY);
      rid(32'h1);
      // Word and stop lengths
      for (int i = 0; i < 8; i++) begin
         wc(UIF_OFS_LINE_FMT, i, UIF_RESP_OKAY);
         rc(UIF_OFS_LINE_FMT, UIF_RESP_OKAY, i);
         chk({27'h0, word_bits, stop_half}, {27'h0, 4'h5 + i[1:0], i[2] ? (i[1:0] == 0 ? 3'h3 : 3'h4) : 3'h2});
      end
      // Parity modes, good then corrupted partner parity
      tx_data <= 8'hE1;
      for (int i = 0; i < 6; i++) begin
         wc(UIF_OFS_LINE_FMT, {24'h0, modes[i]}, UIF_RESP_OKAY);
         fmt_m <= modes[i];
         corrupt <= 1'b0;
         repeat (2) @(posedge CORE_CLK);
         if (modes[i][3]) chk({33'h0, tx_par}, {33'h0, exp_par});
         chk({33'h0, rx_err}, 34'h0);
         corrupt <= 1'b1;
         repeat (2) @(posedge CORE_CLK);
         chk({33'h0, rx_err}, {33'h0, modes[i][3]});
      end
      // Break holds the line low
      wc(UIF_OFS_LINE_FMT, 32'h40, UIF_RESP_OKAY);
      repeat (4) @(posedge CORE_CLK);
      chk({33'h0, tx_out}, 34'h0);
      wc(UIF_OFS_LINE_FMT, 32'h80, UIF_RESP_OKAY);
      repeat (2) @(posedge CORE_CLK);
      chk({32'h0, tx_out, div_acc}, 34'h3);
      // Without break the serial bit passes through
      tx_in <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      chk({33'h0, tx_out}, 34'h0);
      // Divisor window hides identification and FIFO setup
      wc(UIF_OFS_DIVISOR, 32'h1234, UIF_RESP_OKAY);
      rc(UIF_OFS_DIVISOR, UIF_RESP_OKAY, 32'h1234);
      chk({18'h0, divisor}, 34'h1234);
      rc(UIF_OFS_FIFO_SETUP, UIF_RESP_SLVERR, 32'h0);
      rc(UIF_OFS_SOURCE_ID, UIF_RESP_SLVERR, 32'h0);
      wc(UIF_OFS_LINE_FMT, 32'h0, UIF_RESP_OKAY);
      rc(UIF_OFS_DIVISOR, UIF_RESP_SLVERR, 32'h0);
      rid(32'h1);
      end_sim();
   end
endmodule : test_uif_irq_format
